//--- hw/icct_defines.svh
// Operation
// - overflow event pulses when the free counter wraps from all ones to zero.
// - six capture channels, each pulsing its own event on every new capture.
// - a per-channel selector routes any trigger pin to any capture channel.
// - each detected edge overwrites the capture value; unread values are lost.
// - software writes to capture registers are ignored.
// - filtered input changes only after three consecutive ticks at a new level.
// - each channel has a bypass that feeds the synchronised pin straight through.
// - time base divides the block clock by 1 to 128, codes 0 to 7.
// - all timing is derived from the single block clock.
// - two 32-bit compare values, each matched independently against the counter.
// - an enabled compare channel pulses a compare event on match; disabled sends none.
// - each compare channel toggles its output flip-flop on every match.
// - software can force each compare output high or low independently.
// - sleep is allowed only when the block is off or sleep is requested.
// - after sleep the counter continues from its held value.
// - system reset returns every register and all logic to defaults.
// - time base select sits in bits 6 to 4 of the control register at 0x00.
// - force-low clears the output unless force-high is written in the same access.
// - compare enables for channels 1 and 0 sit in control bits 9 and 8.
`ifndef ICCT_DEFINES_SVH
`define ICCT_DEFINES_SVH

// ==================================================================
// register offsets
`define ICCT_OFS_CTRL    8'h00
`define ICCT_OFS_CAPCTL0 8'h04
`define ICCT_OFS_CAPCTL1 8'h08
`define ICCT_OFS_FRT     8'h0c
`define ICCT_OFS_CAP0    8'h10
`define ICCT_OFS_CMP0    8'h28
`define ICCT_OFS_CMP1    8'h2c
`define ICCT_OFS_MUX     8'h30

// ==================================================================
// control register fields
`define ICCT_BIT_BLOCK_ON  0
`define ICCT_BIT_CNT_EN    1
`define ICCT_TBSEL_LSB     4
`define ICCT_TBSEL_MSB     6
`define ICCT_BIT_CMP_EN0   8
`define ICCT_BIT_CMP_EN1   9
`define ICCT_BIT_SET1      16
`define ICCT_BIT_SET0      17
`define ICCT_BIT_CLR1      24
`define ICCT_BIT_CLR0      25

// ==================================================================
// capture control byte per channel: edge[1:0], bypass[2], filter sel[7:5]
`define ICCT_CAP_BYPASS   2
`define ICCT_CAP_FSEL_LSB 5
`define ICCT_MUX_W        4
`define ICCT_PINS         16
`define ICCT_CHANNELS     6
`define ICCT_FILTER_TICKS 2'h2
`define ICCT_RST_WORD     32'h0000_0000
`define ICCT_ALL_ONES     32'hffff_ffff

`endif

//--- hw/icct_pkg.sv
`default_nettype none
package icct_pkg;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_BOTH = 2'h2,
    EDGE_OFF  = 2'h3
  } edge_mode_type;

  typedef struct packed {
    logic [6:0] cnt;
    logic       tick;
  } div_state_type;

  typedef struct packed {
    logic       level;
    logic [1:0] agree;
    logic       prev;
    logic       event_hit;
  } chan_state_type;

  typedef struct packed {
    logic [15:0]       sync1;
    logic [15:0]       sync2;
    logic              block_on;
    logic              cnt_en;
    logic [2:0]        timebase_select;
    logic [1:0]        cmp_en;
    logic [1:0]        tout;
    logic [31:0]       capctl0;
    logic [15:0]       capctl1;
    logic [23:0]       mux;
    logic [31:0]       frt;
    logic [1:0][31:0]  cmp;
    logic [5:0][31:0]  cap;
    logic              ovf_evt;
    logic [5:0]        cap_evt;
    logic [1:0]        cmp_evt;
    logic              sleep_ok;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } icct_state_type;

endpackage : icct_pkg
`default_nettype wire

//--- hw/timebase_divider.sv
`include "icct_defines.svh"
`default_nettype none
module timebase_divider (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [2:0] i_sel,
  output var  logic       o_tick
);

  icct_pkg::div_state_type st_r;
  icct_pkg::div_state_type st_nxt;
  logic [6:0]              mask;

  // ==================================================================
  // power-of-two divide; tick once every 2^sel clocks
  always_comb
  begin
    mask   = 7'((8'h01 << i_sel) - 8'h01);
    st_nxt = st_r;
    if (!i_run)
    begin
      st_nxt.cnt  = 7'h00; // restart so the first period is whole
      st_nxt.tick = 1'b0;
    end
    else
    begin
      st_nxt.cnt  = st_r.cnt + 7'h01;
      st_nxt.tick = ((st_r.cnt & mask) == mask);
    end
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_tick = st_r.tick;

endmodule : timebase_divider
`default_nettype wire

//--- hw/capture_channel.sv
`include "icct_defines.svh"
`default_nettype none
module capture_channel (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic       i_pin,
  input  wire logic [1:0] i_edge,
  input  wire logic       i_bypass,
  input  wire logic [2:0] i_fsel,
  output var  logic       o_event
);

  icct_pkg::chan_state_type st_r;
  icct_pkg::chan_state_type st_nxt;
  logic                     filter_tick;
  logic                     cur;

  timebase_divider u_filter_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (i_run),
    .i_sel     (i_fsel),
    .o_tick    (filter_tick)
  );

  // ==================================================================
  // noise filter and edge detect
  always_comb
  begin
    st_nxt = st_r;
    // level moves only after three ticks in a row at the new value
    if (filter_tick)
    begin
      if (i_pin == st_r.level)
        st_nxt.agree = 2'h0;
      else if (st_r.agree == `ICCT_FILTER_TICKS)
      begin
        st_nxt.level = i_pin;
        st_nxt.agree = 2'h0;
      end
      else
        st_nxt.agree = st_r.agree + 2'h1;
    end
    cur           = i_bypass ? i_pin : st_r.level;
    st_nxt.prev   = cur;
    st_nxt.event_hit = 1'b0;
    // programmed edge choice
    unique case (icct_pkg::edge_mode_type'(i_edge))
      icct_pkg::EDGE_FALL: st_nxt.event_hit = st_r.prev & ~cur;
      icct_pkg::EDGE_RISE: st_nxt.event_hit = ~st_r.prev & cur;
      icct_pkg::EDGE_BOTH: st_nxt.event_hit = st_r.prev ^ cur;
      icct_pkg::EDGE_OFF:  st_nxt.event_hit = 1'b0;
    endcase
    if (!i_run)
      st_nxt.event_hit = 1'b0;
  end

  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_event = st_r.event_hit;

endmodule : capture_channel
`default_nettype wire

//--- hw/input_capture_compare_timer.sv
// Local design decisions: register access over APB and the register offsets.
`include "icct_defines.svh"
`default_nettype none
module input_capture_compare_timer (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output var  logic        o_pready,
  output var  logic [31:0] o_prdata,
  output var  logic        o_pslverr,
  // pins and events
  input  wire logic [15:0] i_capture_trigger_pin,
  output var  logic        o_match_output_zero,
  output var  logic        o_match_output_one,
  output var  logic        o_overflow_evt,
  output var  logic [5:0]  o_capture_evt,
  output var  logic [1:0]  o_compare_evt,
  // power unit handshake
  input  wire logic        i_sleep_req,
  output var  logic        o_sleep_ok
);

  icct_pkg::icct_state_type st_r;
  icct_pkg::icct_state_type st_nxt;

  logic [5:0]  chan_hit;
  logic [5:0]  routed;
  logic [5:0]  chan_byte_bypass;
  logic        count_run;
  logic        count_tick;
  logic        wr_en;
  logic        setup;
  logic [31:0] frt_inc;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [1:0]  set_req;
  logic [1:0]  clr_req;
  logic [1:0]  match;
  logic [47:0] capctl_all;

  // ==================================================================
  // time base
  // sleep freezes the counter instead of clearing it
  assign count_run = st_r.block_on & st_r.cnt_en & ~i_sleep_req;

  timebase_divider u_count_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_run     (count_run),
    .i_sel     (st_r.timebase_select),
    .o_tick    (count_tick)
  );

  // ==================================================================
  // capture channels
  assign capctl_all = {st_r.capctl1, st_r.capctl0};

  genvar k;
  generate
    for (k = 0; k < `ICCT_CHANNELS; k = k + 1)
    begin : g_chan
      // any synchronised pin to any channel
      assign routed[k] = st_r.sync2[st_r.mux[k*`ICCT_MUX_W +: `ICCT_MUX_W]];
      assign chan_byte_bypass[k] = capctl_all[k*8 + `ICCT_CAP_BYPASS];

      capture_channel u_chan (
        .i_sys_clk (i_sys_clk),
        .i_rst_n   (i_rst_n),
        .i_run     (st_r.block_on),
        .i_pin     (routed[k]),
        .i_edge    (capctl_all[k*8 +: 2]),
        .i_bypass  (chan_byte_bypass[k]),
        .i_fsel    (capctl_all[k*8 + `ICCT_CAP_FSEL_LSB +: 3]),
        .o_event   (chan_hit[k])
      );
    end
  endgenerate

  // ==================================================================
  // apb decode: pready is registered in the setup cycle so every access
  // phase lasts exactly one clock
  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & i_pwrite & st_r.pready;

  // read mux; unmapped offsets flag an error
  always_comb
  begin
    rd_word = `ICCT_RST_WORD;
    rd_ok   = 1'b1;
    unique case (i_paddr)
      `ICCT_OFS_CTRL:
      begin
        rd_word[`ICCT_BIT_BLOCK_ON]             = st_r.block_on;
        rd_word[`ICCT_BIT_CNT_EN]               = st_r.cnt_en;
        rd_word[`ICCT_TBSEL_MSB:`ICCT_TBSEL_LSB] = st_r.timebase_select;
        rd_word[`ICCT_BIT_CMP_EN0]              = st_r.cmp_en[0];
        rd_word[`ICCT_BIT_CMP_EN1]              = st_r.cmp_en[1];
        rd_word[`ICCT_BIT_SET0]                 = st_r.tout[0];
        rd_word[`ICCT_BIT_SET1]                 = st_r.tout[1];
        rd_word[`ICCT_BIT_CLR0]                 = st_r.tout[0];
        rd_word[`ICCT_BIT_CLR1]                 = st_r.tout[1];
      end
      `ICCT_OFS_CAPCTL0: rd_word = st_r.capctl0;
      `ICCT_OFS_CAPCTL1: rd_word = {16'h0000, st_r.capctl1};
      `ICCT_OFS_FRT:     rd_word = st_r.frt;
      8'h10:             rd_word = st_r.cap[0];
      8'h14:             rd_word = st_r.cap[1];
      8'h18:             rd_word = st_r.cap[2];
      8'h1c:             rd_word = st_r.cap[3];
      8'h20:             rd_word = st_r.cap[4];
      8'h24:             rd_word = st_r.cap[5];
      `ICCT_OFS_CMP0:    rd_word = st_r.cmp[0];
      `ICCT_OFS_CMP1:    rd_word = st_r.cmp[1];
      `ICCT_OFS_MUX:     rd_word = {8'h00, st_r.mux};
      default:           rd_ok   = 1'b0;
    endcase
  end

  // ==================================================================
  // compare force requests decoded from a control write
  always_comb
  begin
    set_req = 2'b00;
    clr_req = 2'b00;
    if (wr_en && i_paddr == `ICCT_OFS_CTRL)
    begin
      set_req[0] = i_pwdata[`ICCT_BIT_SET0];
      set_req[1] = i_pwdata[`ICCT_BIT_SET1];
      // clear loses to a set of the same output in one access
      clr_req[0] = i_pwdata[`ICCT_BIT_CLR0] & ~i_pwdata[`ICCT_BIT_SET0];
      clr_req[1] = i_pwdata[`ICCT_BIT_CLR1] & ~i_pwdata[`ICCT_BIT_SET1];
    end
  end

  // matches are judged on the value the counter is about to take, so a
  // slow time base gives one event per match, not one per clock
  assign frt_inc  = st_r.frt + 32'h0000_0001; // natural 32-bit wrap
  assign match[0] = count_tick & st_r.cmp_en[0] & (frt_inc == st_r.cmp[0]);
  assign match[1] = count_tick & st_r.cmp_en[1] & (frt_inc == st_r.cmp[1]);

  // ==================================================================
  // next state
  always_comb
  begin
    st_nxt = st_r;

    // two-flop synchroniser on every pin
    st_nxt.sync1 = i_capture_trigger_pin;
    st_nxt.sync2 = st_r.sync1;

    // free-running counter and wrap event
    st_nxt.ovf_evt = 1'b0;
    if (count_tick)
    begin
      st_nxt.frt     = frt_inc;
      st_nxt.ovf_evt = (st_r.frt == `ICCT_ALL_ONES);
    end

    // capture: overwrite, older value lost, event each time
    for (int c = 0; c < `ICCT_CHANNELS; c++)
    begin
      st_nxt.cap_evt[c] = chan_hit[c];
      if (chan_hit[c])
        st_nxt.cap[c] = st_r.frt;
    end

    // compare events and toggle flops
    st_nxt.cmp_evt = match;
    st_nxt.tout    = st_r.tout ^ match;
    // software force overrides a simultaneous toggle
    st_nxt.tout = (st_nxt.tout | set_req) & ~clr_req;

    // register writes; capture words are read-only
    if (wr_en)
    begin
      unique case (i_paddr)
        `ICCT_OFS_CTRL:
        begin
          st_nxt.block_on  = i_pwdata[`ICCT_BIT_BLOCK_ON];
          st_nxt.cnt_en    = i_pwdata[`ICCT_BIT_CNT_EN];
          st_nxt.timebase_select = i_pwdata[`ICCT_TBSEL_MSB:`ICCT_TBSEL_LSB];
          st_nxt.cmp_en[0] = i_pwdata[`ICCT_BIT_CMP_EN0];
          st_nxt.cmp_en[1] = i_pwdata[`ICCT_BIT_CMP_EN1];
        end
        `ICCT_OFS_CAPCTL0: st_nxt.capctl0 = i_pwdata;
        `ICCT_OFS_CAPCTL1: st_nxt.capctl1 = i_pwdata[15:0];
        // a software load wins over a tick in the same cycle
        `ICCT_OFS_FRT:     st_nxt.frt     = i_pwdata;
        `ICCT_OFS_CMP0:    st_nxt.cmp[0]  = i_pwdata;
        `ICCT_OFS_CMP1:    st_nxt.cmp[1]  = i_pwdata;
        `ICCT_OFS_MUX:     st_nxt.mux     = i_pwdata[23:0];
        default:           st_nxt.mux     = st_r.mux; // writes elsewhere dropped
      endcase
    end

    // low power only while off or asked to sleep
    st_nxt.sleep_ok = ~st_r.block_on | i_sleep_req;

    // apb answer registered in setup, shown during access
    st_nxt.pready  = setup;
    st_nxt.pslverr = setup & ~rd_ok;
    if (setup && !i_pwrite)
      st_nxt.prdata = rd_word;
  end

  // ==================================================================
  // single state register; async reset loads constants only
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ==================================================================
  // outputs straight from flops
  assign o_pready            = st_r.pready;
  assign o_prdata            = st_r.prdata;
  assign o_pslverr           = st_r.pslverr;
  assign o_match_output_zero = st_r.tout[0];
  assign o_match_output_one  = st_r.tout[1];
  assign o_overflow_evt      = st_r.ovf_evt;
  assign o_capture_evt       = st_r.cap_evt;
  assign o_compare_evt       = st_r.cmp_evt; // already gated by the cmp_en bits in match
  assign o_sleep_ok          = st_r.sleep_ok;

endmodule : input_capture_compare_timer
`default_nettype wire

//--- tb/event_aggregator_model.sv
`default_nettype none
module event_aggregator_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [8:0] i_evt,
  input  wire logic [8:0] i_en,
  output var  logic       o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] sts_r;
  // ========
  // sticky source status, cleared only by reset: each source is used once per run
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
      sts_r <= 9'h000;
    else
      sts_r <= sts_r | i_evt;
  assign o_irq = |(sts_r & i_en);
endmodule : event_aggregator_model
`default_nettype wire

//--- tb/icct_checker_sva.sv
`default_nettype none
module icct_checker (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic [15:0] i_capture_trigger_pin,
  input wire logic        o_match_output_zero,
  input wire logic        o_match_output_one,
  input wire logic        o_overflow_evt,
  input wire logic [5:0]  o_capture_evt,
  input wire logic [1:0]  o_compare_evt,
  input wire logic        i_sleep_req,
  input wire logic        o_sleep_ok
);
  logic       ctrl_wr;
  logic [4:0] ctl_sh_r;
  // ========
  // shadow of enables and time base, taken at the same edge as the design
  assign ctrl_wr = i_psel & i_penable & o_pready & i_pwrite & (i_paddr == 8'h00);
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
    if (!i_rst_n)
      ctl_sh_r <= 5'h00;
    else if (ctrl_wr)
      ctl_sh_r <= {i_pwdata[9:8], i_pwdata[6:4]};
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ========
  property p_ovf_pulse;
    o_overflow_evt |=> !o_overflow_evt;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse)
    else $error("overflow pulse longer than one cycle");
  property p_cmp_en;
    (o_compare_evt & ~$past(ctl_sh_r[4:3])) == 2'h0;
  endproperty
  a_cmp_en: assert property (p_cmp_en)
    else $error("compare event from a disabled channel");
  property p_toggle;
    o_compare_evt[0] && !$past(ctrl_wr) |-> o_match_output_zero != $past(o_match_output_zero);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("match output did not toggle");
  property p_force_high;
    ctrl_wr && i_pwdata[16] |=> o_match_output_one;
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("force high ignored");
  property p_force_low;
    ctrl_wr && i_pwdata[25] && !i_pwdata[17] && !i_pwdata[16] |=> !o_match_output_zero;
  endproperty
  a_force_low: assert property (p_force_low)
    else $error("force low ignored");
  property p_sleep;
    i_sleep_req |=> o_sleep_ok;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep request not granted");
  property p_reset_quiet;
    $rose(i_rst_n) |-> !o_pready && !o_sleep_ok && !o_match_output_zero && o_capture_evt == 6'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not at default after reset");
  property p_ctrl_read;
    o_pready && !i_pwrite && i_paddr == 8'h00 |-> {o_prdata[9:8], o_prdata[6:4]} == ctl_sh_r;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read back differs");
  c_ovf: cover property (o_overflow_evt);
  c_cap: cover property (|o_capture_evt);
  c_cmp: cover property (o_compare_evt[1]);
  c_err: cover property (o_pslverr);
endmodule : icct_checker
bind input_capture_compare_timer icct_checker u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
  .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_capture_trigger_pin(i_capture_trigger_pin),
  .o_match_output_zero(o_match_output_zero), .o_match_output_one(o_match_output_one),
  .o_overflow_evt(o_overflow_evt), .o_capture_evt(o_capture_evt),
  .o_compare_evt(o_compare_evt), .i_sleep_req(i_sleep_req), .o_sleep_ok(o_sleep_ok));
`default_nettype wire

//--- tb/tb_input_capture_compare_timer.sv
`default_nettype none
module tb_input_capture_compare_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, keep;
  logic [15:0] pins = 16'h0;
  logic        sleep_req = 1'b0, pready, pslverr, out0, out1, ovf, sleep_ok, irq, err;
  logic [8:0]  agg_en = 9'h002;
  logic [5:0]  cap_evt;
  logic [1:0]  cmp_evt;
  int          err_count = 0;
  int          total_checks = 0;
  input_capture_compare_timer u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_capture_trigger_pin(pins),
    .o_match_output_zero(out0), .o_match_output_one(out1), .o_overflow_evt(ovf),
    .o_capture_evt(cap_evt), .o_compare_evt(cmp_evt), .i_sleep_req(sleep_req),
    .o_sleep_ok(sleep_ok));
  event_aggregator_model u_agg (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_evt({ovf, cap_evt, cmp_evt}), .i_en(agg_en), .o_irq(irq));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // ========
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      err_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    // hand back off the edge so callers see settled outputs
    @(negedge clk);
  endtask : apb
  // waits for an event bit; a missing wanted event ends the run
  task automatic evt(input logic [8:0] mask, input int lim, input logic want);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++)
    begin
      @(negedge clk);
      hit = |({ovf, cap_evt, cmp_evt} & mask);
    end
    if (want && !hit)
    begin
      err_count++;
      conclude();
    end
    if (!want)
      check(hit, 1'b0);
  endtask : evt
  task automatic pin(input int k, input logic v);
    @(posedge clk);
    pins[k] <= v;
  endtask : pin
  // ========
  task automatic t_reset();
    logic [7:0] regs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h28, 8'h2c, 8'h30};
    foreach (regs[i])
    begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 8'h34, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
  endtask : t_reset
  task automatic t_force();
    apb(1'b1, 8'h00, 32'h0003_0000);
    check({out1, out0}, 2'b11);
    apb(1'b1, 8'h00, 32'h0100_0000);
    check({out1, out0}, 2'b01);
    apb(1'b1, 8'h00, 32'h0202_0000);
    apb(1'b1, 8'h00, 32'h0000_0000);
    check({out1, out0}, 2'b01);
    apb(1'b0, 8'h00, 32'h0);
    check({rd[25:24], rd[17:16]}, 4'ha);
  endtask : t_force
  task automatic t_compare();
    apb(1'b1, 8'h28, 32'h40);
    apb(1'b1, 8'h2c, 32'h60);
    apb(1'b1, 8'h00, 32'h0300_0000);
    apb(1'b1, 8'h00, 32'h0000_0303);
    evt(9'h001, 200, 1'b1);
    @(negedge clk);
    check({out1, out0, irq}, 3'b010);
    evt(9'h002, 200, 1'b1);
    @(negedge clk);
    check({out1, out0, irq}, 3'b111);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h00, 32'h0000_0103);
    evt(9'h002, 150, 1'b0);
  endtask : t_compare
  task automatic t_overflow_sleep();
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h0c, 32'hffff_fff0);
    apb(1'b1, 8'h00, 32'h3);
    evt(9'h100, 40, 1'b1);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd < 32'h20, 1'b1);
    @(posedge clk);
    sleep_req <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    keep = rd;
    check(sleep_ok, 1'b1);
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd, keep);
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b0, 8'h0c, 32'h0);
    check(rd > keep && rd < keep + 32'h10, 1'b1);
    check(sleep_ok, 1'b0);
    apb(1'b1, 8'h00, 32'h0);
    @(negedge clk);
    check(sleep_ok, 1'b1);
  endtask : t_overflow_sleep
  task automatic t_timebase();
    logic [31:0] exp;
    for (int s = 0; s < 8; s++)
    begin
      apb(1'b1, 8'h0c, 32'h0);
      apb(1'b1, 8'h00, {25'h0, s[2:0], 4'h3});
      repeat (1020) @(posedge clk);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      exp = 32'd1024 >> s;
      check(rd + 32'd2 >= exp && rd <= exp + 32'd2, 1'b1);
    end
  endtask : t_timebase
  task automatic t_capture();
    logic [31:0] c0;
    apb(1'b1, 8'h30, 32'h00dc_ba98); // channel k listens to pin k+8
    apb(1'b1, 8'h04, 32'h0505_0505);
    apb(1'b1, 8'h08, 32'h0000_0505);
    apb(1'b1, 8'h00, 32'h3);
    for (int k = 0; k < 6; k++)
    begin
      pin(k + 8, 1'b1);
      evt(9'h004 << k, 20, 1'b1);
      check(cap_evt, 6'h01 << k);
      apb(1'b0, 8'h0c, 32'h0);
      keep = rd;
      apb(1'b0, 8'h10 + 8'(4 * k), 32'h0);
      check(rd != 32'h0 && rd < keep, 1'b1);
      if (k == 0)
        c0 = rd;
    end
    apb(1'b1, 8'h10, 32'h1234_5678);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, c0);
    pin(8, 1'b0);
    evt(9'h004, 20, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, 8'h04, {24'h050505, 6'h01, m[1:0]});
      pin(8, 1'b1);
      evt(9'h004, 20, m == 1 || m == 2);
      pin(8, 1'b0);
      evt(9'h004, 20, m == 0 || m == 2);
    end
    apb(1'b0, 8'h10, 32'h0);
    check(rd > c0, 1'b1);
    apb(1'b1, 8'h04, 32'h0505_0501);
    pin(8, 1'b1);
    pin(8, 1'b1);
    pin(8, 1'b0);
    evt(9'h004, 20, 1'b0);
    pin(8, 1'b1);
    evt(9'h004, 20, 1'b1);
  endtask : t_capture
  // ========
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_force();
    t_compare();
    t_overflow_sleep();
    t_timebase();
    t_capture();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    conclude();
  end
endmodule : tb_input_capture_compare_timer
`default_nettype wire
